// ### hdl/uhie_core.sv
// core: one uart channel's holding registers, receiver start check, enable mask, line status and interrupt
module uhie_core
  import uhie_pkg::*;
#(
  parameter logic BUS68 = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire uhie_bus_t bus,
  output logic [7:0] rdata,
  input wire uhie_ctl_t ctl,
  input wire logic tick16,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic chan_int,
  output logic irq_n_o,
  output logic irq_n_oe_n,
  output logic sleep_allowed,
  output logic tx_space
);

  logic [7:0] interrupt_enable_mask;
  logic [7:0] line_control;
  logic normal_bank;
  logic host_wr;
  logic host_rd;
  logic [7:0] tx_word;
  logic tx_word_valid;
  logic tx_fifo_ready;
  logic [UHIE_FIFO_AW:0] tx_level;
  logic [7:0] tx_shift;
  logic [3:0] tx_bitcnt;
  logic [3:0] tx_tick;
  logic tx_busy;
  logic tx_pull;
  logic tx_avail;
  logic [7:0] tx_head;
  logic tx_hold_free;
  logic [7:0] rx_word;
  logic rx_push;
  logic rx_fifo_ready;
  logic rx_avail;
  logic [UHIE_FIFO_AW:0] rx_level;
  logic rx_pop;
  logic [7:0] rx_head;
  logic [2:0] rx_sync;
  logic rx_line;
  logic rx_line_d;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} uhie_rx_t;
  uhie_rx_t rx_state;
  logic [3:0] rx_tick;
  logic [3:0] rx_bits;
  logic [7:0] rx_shift;
  logic overrun;
  logic framing;
  logic line_event;
  logic cts_d;
  logic rts_d;
  logic cts_event;
  logic rts_event;
  logic rx_trig;
  logic [7:0] interrupt_source_status;
  logic [7:0] line_status;
  logic any_int;

  // address decode: data and mask registers hide behind the divisor-latch bit
  function automatic logic hit(input uhie_bus_t b, input logic [2:0] a);
    return b.cs && (b.addr == a);
  endfunction
  assign normal_bank = !line_control[UHIE_LCR_DLAB];
  assign host_wr = hit(bus, UHIE_ADDR_HOLDING) && bus.wr && normal_bank;
  assign host_rd = hit(bus, UHIE_ADDR_HOLDING) && bus.rd && normal_bank;

  // mask register: cleared at reset so every source and sleep start off
  // a write under the divisor-latch bit is dropped, not deferred
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      interrupt_enable_mask <= UHIE_IER_RESET;
    end else if (hit(bus, UHIE_ADDR_IER) && bus.wr && normal_bank) begin
      interrupt_enable_mask <= bus.wdata;
    end
  end
  // line control is always reachable: it is the only way back to the normal bank
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      line_control <= UHIE_LCR_RESET;
    end else if (hit(bus, UHIE_ADDR_LCR) && bus.wr) begin
      line_control <= bus.wdata;
    end
  end
  // sleep itself lives outside; this only passes the permission on, one clock late
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sleep_allowed <= 1'b0;
    end else begin
      sleep_allowed <= interrupt_enable_mask[UHIE_IER_SLEEP];
    end
  end

  // transmit holding path: a full fifo refuses the write rather than overwrite
  // with fifos off the holding stage is a single byte, so a second write is dropped until the shifter takes the first
  assign tx_hold_free = ctl.fifo_en || (tx_level == '0);
  assign tx_word_valid = host_wr && tx_hold_free;
  assign tx_word = bus.wdata;
  // flush is held low: clearing the fifos belongs to the control register outside
  uhie_fifo #(.WIDTH(UHIE_DATA_W), .DEPTH(UHIE_FIFO_DEPTH), .AW(UHIE_FIFO_AW)) u_tx_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(1'b0),
    .in_valid(tx_word_valid),
    .in_ready(tx_fifo_ready),
    .in_data(tx_word),
    .out_valid(tx_avail),
    .out_ready(tx_pull),
    .out_data(tx_head),
    .level(tx_level)
  );
  // the shifter takes the head as soon as it is idle
  assign tx_pull = tx_avail && !tx_busy;

  // transmit shifter: start, eight data bits, one stop, each sixteen ticks
  // the stop bit is a full bit time; the next frame may start the clock after busy drops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_busy <= 1'b0;
      tx_shift <= 8'h00;
      tx_bitcnt <= 4'h0;
      tx_tick <= 4'h0;
      tx_pin <= 1'b1;
    end else if (tx_pull) begin
      tx_busy <= 1'b1;
      tx_shift <= tx_head;
      tx_bitcnt <= 4'h0;
      tx_tick <= 4'h0;
      tx_pin <= 1'b0;
    end else if (tx_busy && tick16) begin
      tx_tick <= tx_tick + 4'h1;
      if (tx_tick == UHIE_BIT_LAST) begin
        tx_bitcnt <= tx_bitcnt + 4'h1;
        if (tx_bitcnt == UHIE_DATA_BITS + 4'h1) begin
          tx_busy <= 1'b0;
        end else if (tx_bitcnt == UHIE_DATA_BITS) begin
          tx_pin <= 1'b1;
        end else begin
          tx_pin <= tx_shift[0];
          tx_shift <= {1'b0, tx_shift[7:1]};
        end
      end
    end
  end

  // serial input crosses in through three flops; change counts when last two agree
  // a one-clock spike at the pin never reaches the receiver
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_sync <= 3'h7;
      rx_line <= 1'b1;
      rx_line_d <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_pin};
      if (rx_sync[2] == rx_sync[1]) begin
        rx_line <= rx_sync[2];
      end
      rx_line_d <= rx_line;
    end
  end

  // receiver: a glitch shorter than half a bit is thrown away as a false start
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_state <= RX_IDLE;
      rx_tick <= 4'h0;
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
      rx_push <= 1'b0;
      framing <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      unique case (rx_state)
        RX_IDLE: begin
          rx_tick <= 4'h0;
          if (rx_line_d && !rx_line) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick16) begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == UHIE_START_MID) begin
              rx_tick <= 4'h0;
              rx_bits <= 4'h0;
              // a high line at mid-start is noise, not a character
              rx_state <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick16) begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == UHIE_BIT_LAST) begin
              // each bit is taken sixteen ticks after the previous sample, near its centre
              rx_shift <= {rx_line, rx_shift[7:1]};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == UHIE_DATA_BITS - 4'h1) begin
                rx_state <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick16) begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == UHIE_BIT_LAST) begin
              rx_push <= 1'b1;
              // a low stop bit is kept as a framing error against this character
              framing <= !rx_line;
              rx_state <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign rx_word = rx_shift;

  // receive fifo: the head is the receive holding register
  uhie_fifo #(.WIDTH(UHIE_DATA_W), .DEPTH(UHIE_FIFO_DEPTH), .AW(UHIE_FIFO_AW)) u_rx_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(1'b0),
    .in_valid(rx_push),
    .in_ready(rx_fifo_ready),
    .in_data(rx_word),
    .out_valid(rx_avail),
    .out_ready(rx_pop),
    .out_data(rx_head),
    .level(rx_level)
  );
  assign rx_pop = host_rd;

  // sticky error and character-arrival events; a new event beats the read that clears it
  // a character arriving at a full fifo is lost and only flagged
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      overrun <= 1'b0;
      line_event <= 1'b0;
    end else begin
      if (rx_push && !rx_fifo_ready) begin
        overrun <= 1'b1;
      end else if (hit(bus, UHIE_ADDR_LSR) && bus.rd) begin
        overrun <= 1'b0;
      end
      if (rx_push) begin
        line_event <= 1'b1;
      end else if (hit(bus, UHIE_ADDR_LSR) && bus.rd) begin
        line_event <= 1'b0;
      end
    end
  end

  // rising edges of the flow-control lines
  // the events latch even while masked, so a late enable shows an old edge until status is read
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cts_d <= 1'b0;
      rts_d <= 1'b0;
      cts_event <= 1'b0;
      rts_event <= 1'b0;
    end else begin
      cts_d <= ctl.cts;
      rts_d <= ctl.rts;
      if (ctl.cts && !cts_d) begin
        cts_event <= 1'b1;
      end else if (hit(bus, UHIE_ADDR_ISR) && bus.rd) begin
        cts_event <= 1'b0;
      end
      if (ctl.rts && !rts_d) begin
        rts_event <= 1'b1;
      end else if (hit(bus, UHIE_ADDR_ISR) && bus.rd) begin
        rts_event <= 1'b0;
      end
    end
  end

  // receive trigger is a level, so it drops by itself once the fifo drains below it
  // without fifos the trigger collapses to data ready
  assign rx_trig = ctl.fifo_en ? (rx_level >= ctl.rx_trigger) : rx_avail;

  // line status; reads are live, polled operation needs no enable bit
  // parity and break bits stay zero: those checks live outside this core
  always_comb begin
    line_status = 8'h00;
    line_status[0] = rx_avail;
    line_status[1] = overrun;
    line_status[3] = framing;
    line_status[5] = ctl.fifo_en ? tx_fifo_ready : !tx_avail;
    line_status[6] = (tx_level == '0) && !tx_busy;
    line_status[7] = ctl.fifo_en && framing;
  end

  // source status in priority order; the fifo bits show when fifos are on
  // only one source shows at a time; lower ones wait until the higher clears
  always_comb begin
    interrupt_source_status = UHIE_ISR_NONE;
    if (interrupt_enable_mask[UHIE_IER_RXLINE] && (line_event || overrun)) begin
      interrupt_source_status = UHIE_ISR_LINE;
    end else if (interrupt_enable_mask[UHIE_IER_RXDATA] && rx_trig) begin
      interrupt_source_status = UHIE_ISR_RXDATA;
    end else if (interrupt_enable_mask[UHIE_IER_TXEMPTY] && line_status[5]) begin
      interrupt_source_status = UHIE_ISR_TXEMPTY;
    end else if (interrupt_enable_mask[UHIE_IER_MODEM] && ctl.modem_change) begin
      interrupt_source_status = UHIE_ISR_MODEM;
    end else if (interrupt_enable_mask[UHIE_IER_XOFF] && ctl.xoff_seen) begin
      interrupt_source_status = UHIE_ISR_XOFF;
    end else if ((interrupt_enable_mask[UHIE_IER_CTS] && cts_event) || (interrupt_enable_mask[UHIE_IER_RTS] && rts_event)) begin
      interrupt_source_status = UHIE_ISR_FLOW;
    end
    if (ctl.fifo_en) begin
      interrupt_source_status = interrupt_source_status | UHIE_ISR_FIFO_ON;
    end
  end
  assign any_int = !interrupt_source_status[0];

  // registered read data and interrupt pins
  // a data read pops the fifo on the same edge, so rdata carries the old head
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata <= 8'h00;
      chan_int <= 1'b0;
      irq_n_o <= 1'b0;
      irq_n_oe_n <= 1'b1;
      tx_space <= 1'b1;
    end else begin
      rdata <= 8'h00;
      if (bus.cs && bus.rd) begin
        unique case (bus.addr)
          UHIE_ADDR_HOLDING: rdata <= normal_bank ? rx_head : 8'h00;
          UHIE_ADDR_IER: rdata <= normal_bank ? interrupt_enable_mask : 8'h00;
          UHIE_ADDR_ISR: rdata <= interrupt_source_status;
          UHIE_ADDR_LCR: rdata <= line_control;
          UHIE_ADDR_LSR: rdata <= line_status;
          default: rdata <= 8'h00;
        endcase
      end
      chan_int <= !BUS68 && any_int;
      irq_n_oe_n <= !(BUS68 && any_int);
      irq_n_o <= 1'b0;
      tx_space <= line_status[5];
    end
  end
  // each channel is a separate instance of this module
  // no state is shared between instances, so channels never disturb one another
endmodule

// ### hdl/uhie_pkg.sv
// package: register addresses, field positions, reset values and carriers for one uart channel core
package uhie_pkg;
  localparam logic [2:0] UHIE_ADDR_HOLDING = 3'h0;
  localparam logic [2:0] UHIE_ADDR_IER = 3'h1;
  localparam logic [2:0] UHIE_ADDR_ISR = 3'h2;
  localparam logic [2:0] UHIE_ADDR_LCR = 3'h3;
  localparam logic [2:0] UHIE_ADDR_LSR = 3'h5;
  localparam logic [7:0] UHIE_IER_RESET = 8'h00;
  localparam logic [7:0] UHIE_LCR_RESET = 8'h00;
  localparam int UHIE_LCR_DLAB = 7;
  localparam int UHIE_IER_CTS = 7;
  localparam int UHIE_IER_RTS = 6;
  localparam int UHIE_IER_XOFF = 5;
  localparam int UHIE_IER_SLEEP = 4;
  localparam int UHIE_IER_MODEM = 3;
  localparam int UHIE_IER_RXLINE = 2;
  localparam int UHIE_IER_TXEMPTY = 1;
  localparam int UHIE_IER_RXDATA = 0;
  localparam int UHIE_FIFO_DEPTH = 16;
  localparam int UHIE_FIFO_AW = 4;
  localparam int UHIE_DATA_W = 8;
  localparam logic [7:0] UHIE_ISR_NONE = 8'h01;
  localparam logic [7:0] UHIE_ISR_LINE = 8'h06;
  localparam logic [7:0] UHIE_ISR_RXDATA = 8'h04;
  localparam logic [7:0] UHIE_ISR_TXEMPTY = 8'h02;
  localparam logic [7:0] UHIE_ISR_MODEM = 8'h00;
  localparam logic [7:0] UHIE_ISR_XOFF = 8'h10;
  localparam logic [7:0] UHIE_ISR_FLOW = 8'h20;
  localparam logic [7:0] UHIE_ISR_FIFO_ON = 8'hC0;
  // half of the sixteen sample ticks, minus one: sample the start bit on the eighth tick
  localparam logic [3:0] UHIE_START_MID = 4'h7;
  localparam logic [3:0] UHIE_BIT_LAST = 4'hF;
  localparam logic [3:0] UHIE_DATA_BITS = 4'h8;
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uhie_bus_t;
  typedef struct packed {
    logic fifo_en;
    logic [4:0] rx_trigger;
    logic tx_trigger_hit;
    logic rts;
    logic cts;
    logic xoff_seen;
    logic modem_change;
  } uhie_ctl_t;
endpackage

// ### hdl/uhie_fifo.sv
// fifo: parameterised first-in first-out store with valid/ready on both sides
module uhie_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic push;
  logic pop;
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rptr];
  // storage is not reset; only the pointers matter
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst || flush) begin
      wptr <= '0;
      rptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + AW'(1);
      end
      if (pop) begin
        rptr <= rptr + AW'(1);
      end
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### bench/uhie_core_sva.sv
// checker: port-level assertions for one uart channel core
module uhie_core_chk
  import uhie_pkg::*;
#(
  parameter logic BUS68 = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire uhie_bus_t bus,
  input wire logic [7:0] rdata,
  input wire uhie_ctl_t ctl,
  input wire logic tick16,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic chan_int,
  input wire logic irq_n_o,
  input wire logic irq_n_oe_n,
  input wire logic sleep_allowed,
  input wire logic tx_space
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic int_seen;
  logic [7:0] lcr_copy;
  logic [7:0] mask_copy;
  logic [7:0] mask_int;
  logic locked;
  logic rd_lo;
  assign locked = lcr_copy[UHIE_LCR_DLAB];
  assign mask_int = mask_copy & 8'hEF;
  assign rd_lo = bus.cs && bus.rd && (bus.addr <= UHIE_ADDR_IER);
  // the interrupt shows on the per-channel pin or as a driven shared request
  assign int_seen = BUS68 ? !irq_n_oe_n : chan_int;
  // shadow of line control, so the lock on the low addresses can be judged
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lcr_copy <= UHIE_LCR_RESET;
    end else if (bus.cs && bus.wr && bus.addr == UHIE_ADDR_LCR) begin
      lcr_copy <= bus.wdata;
    end
  end
  // shadow of the enable mask; writes under the lock must not land
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_copy <= UHIE_IER_RESET;
    end else if (bus.cs && bus.wr && bus.addr == UHIE_ADDR_IER && !locked) begin
      mask_copy <= bus.wdata;
    end
  end
  chk_rdata_idle: assert property (!(bus.cs && bus.rd) |=> rdata == 8'h00)
    else $error("read data not cleared");
  chk_mask_read: assert property (rd_lo && bus.addr == UHIE_ADDR_IER && !locked |=> rdata == $past(mask_copy))
    else $error("mask read differs");
  chk_hold_lock: assert property (rd_lo && locked |=> rdata == 8'h00)
    else $error("locked read not zero");
  chk_sleep_follow: assert property ($stable(mask_copy) |-> sleep_allowed == mask_copy[UHIE_IER_SLEEP])
    else $error("sleep permission wrong");
  chk_int_quiet: assert property ($stable(mask_int) && mask_int == 8'h00 |-> !int_seen)
    else $error("interrupt while masked");
  chk_cts_int: assert property ($rose(ctl.cts) && mask_copy[UHIE_IER_CTS] |-> ##[1:3] int_seen)
    else $error("no interrupt on cts rise");
  chk_rts_int: assert property ($rose(ctl.rts) && mask_copy[UHIE_IER_RTS] |-> ##[1:3] int_seen)
    else $error("no interrupt on rts rise");
  chk_shared_quiet: assert property (BUS68 |-> !chan_int)
    else $error("per-channel output driven in shared mode");
  chk_irq_low: assert property (irq_n_o == 1'b0)
    else $error("shared request level not low");
  chk_oe_mode: assert property (!BUS68 |-> irq_n_oe_n)
    else $error("shared request driven in per-channel mode");
  chk_space_match: assert property (bus.cs && bus.rd && bus.addr == UHIE_ADDR_LSR |=> rdata[5] == tx_space)
    else $error("space flag and status differ");
  cover property (bus.cs && bus.rd && bus.addr == UHIE_ADDR_HOLDING);
  cover property ($rose(chan_int));
  cover property (!tx_space);
endmodule

bind uhie_core uhie_core_chk #(.BUS68(BUS68)) chk_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus),
  .rdata(rdata), .ctl(ctl), .tick16(tick16), .rx_pin(rx_pin), .tx_pin(tx_pin), .chan_int(chan_int),
  .irq_n_o(irq_n_o), .irq_n_oe_n(irq_n_oe_n), .sleep_allowed(sleep_allowed), .tx_space(tx_space));

// ### bench/uhie_line_partner.sv
// partner: serial line peer, 8N1 at sixteen ticks per bit, lsb first
module uhie_line_partner (
  input wire logic clk_sys,
  input wire logic tick16,
  input wire logic tx_pin,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [7:0] rx_b;
  initial rx_pin = 1'b1;
  task automatic wait_ticks(input int n);
    repeat (n) @(posedge clk_sys iff tick16);
  endtask
  // whole frame: start, eight data bits, stop; line idles high after
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin = f[i];
      wait_ticks(16);
      #1;
    end
  endtask
  // low pulse shorter than half a bit must be thrown away
  task automatic glitch();
    rx_pin = 1'b0;
    wait_ticks(4);
    #1 rx_pin = 1'b1;
  endtask
  // receiver samples mid-bit, a bit and a half after the start edge
  initial forever begin
    @(negedge tx_pin);
    wait_ticks(24);
    for (int i = 0; i < 8; i++) begin
      rx_b[i] = tx_pin;
      wait_ticks(16);
    end
    got_q.push_back(rx_b);
  end
endmodule

// ### bench/tb_uart_holding_and_interrupt_enable.sv
// testbench: register bus and serial line stimulus for the channel core
module tb_uart_holding_and_interrupt_enable;
  import uhie_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic tick16 = 1'b0;
  logic [1:0] tcnt = 2'h0;
  uhie_bus_t bus = '0;
  uhie_ctl_t ctl = '0;
  logic rx_pin;
  logic tx_pin;
  logic chan_int;
  logic sleep_allowed;
  logic tx_space;
  logic shared_oe_n;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [7:0] exp_q[$];
  logic [7:0] ev_mask [4] = '{8'h80, 8'h40, 8'h20, 8'h08};
  logic [7:0] ev_code [4] = '{8'hE0, 8'hE0, 8'hD0, 8'hC0};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  uhie_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .ctl(ctl), .tick16(tick16),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .chan_int(chan_int), .irq_n_o(), .irq_n_oe_n(),
    .sleep_allowed(sleep_allowed), .tx_space(tx_space));
  // a second channel in shared-request mode sees the same bus and line
  uhie_core #(.BUS68(1'b1)) dut_shared (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus), .rdata(), .ctl(ctl),
    .tick16(tick16), .rx_pin(rx_pin), .tx_pin(), .chan_int(), .irq_n_o(), .irq_n_oe_n(shared_oe_n),
    .sleep_allowed(), .tx_space());
  uhie_line_partner line (.clk_sys(clk_sys), .tick16(tick16), .tx_pin(tx_pin), .rx_pin(rx_pin));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // a tick every fourth clock keeps frames short
  always @(posedge clk_sys) begin
    #1 tcnt = tcnt + 2'h1;
    tick16 = (tcnt == 2'h0);
  end
  // hang guard, well above the longest expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 bus = {3'b101, a, d};
    @(posedge clk_sys);
    #1 bus = '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 bus = {3'b110, a, 8'h00};
    @(posedge clk_sys);
    #1 bus = '0;
    d = rdata;
  endtask
  task automatic ev_set(input int i, input logic s);
    case (i)
      0: ctl.cts = s;
      1: ctl.rts = s;
      2: ctl.xoff_seen = s;
      default: ctl.modem_change = s;
    endcase
  endtask
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(28));
    ctl.fifo_en = 1'b1;
    ctl.rx_trigger = 5'h02;
    waitc(8);
    sys_rst = 1'b0;
    rd(UHIE_ADDR_IER, v);
    check(v, UHIE_IER_RESET);
    rd(UHIE_ADDR_LSR, v);
    check(v, 8'h60);
    end_test("reset");
    wr(UHIE_ADDR_IER, 8'h10);
    waitc(2);
    check({7'h00, sleep_allowed}, 8'h01);
    wr(UHIE_ADDR_LCR, 8'h80);
    wr(UHIE_ADDR_IER, 8'h00);
    rd(UHIE_ADDR_IER, v);
    check(v, 8'h00);
    wr(UHIE_ADDR_LCR, 8'h00);
    rd(UHIE_ADDR_IER, v);
    check(v, 8'h10);
    wr(UHIE_ADDR_IER, 8'h00);
    end_test("mask");
    // trigger level two: first byte stays quiet, second raises
    wr(UHIE_ADDR_IER, 8'h01);
    for (int i = 0; i < 2; i++) begin
      exp_q.push_back(8'($urandom));
      line.send_byte(exp_q[i]);
      waitc(4);
      check({7'h00, chan_int}, {7'h00, i[0]});
    end
    rd(UHIE_ADDR_ISR, v);
    check(v, UHIE_ISR_RXDATA | UHIE_ISR_FIFO_ON);
    for (int i = 0; i < 2; i++) begin
      rd(UHIE_ADDR_LSR, v);
      check({7'h00, v[0]}, 8'h01);
      rd(UHIE_ADDR_HOLDING, v);
      check(v, exp_q.pop_front());
      waitc(2);
      check({7'h00, chan_int}, 8'h00);
    end
    line.glitch();
    waitc(700);
    rd(UHIE_ADDR_LSR, v);
    check({7'h00, v[0]}, 8'h00);
    wr(UHIE_ADDR_IER, 8'h00);
    end_test("receive");
    // each event source masked first, then enabled
    for (int i = 0; i < 4; i++) begin
      ev_set(i, 1'b1);
      waitc(3);
      check({7'h00, chan_int}, 8'h00);
      ev_set(i, 1'b0);
      rd(UHIE_ADDR_ISR, v);
      wr(UHIE_ADDR_IER, ev_mask[i]);
      ev_set(i, 1'b1);
      waitc(3);
      check({7'h00, chan_int}, 8'h01);
      check({7'h00, !shared_oe_n}, 8'h01);
      rd(UHIE_ADDR_ISR, v);
      check(v, ev_code[i]);
      ev_set(i, 1'b0);
      rd(UHIE_ADDR_ISR, v);
      waitc(3);
      check({7'h00, chan_int}, 8'h00);
      check({7'h00, shared_oe_n}, 8'h01);
      wr(UHIE_ADDR_IER, 8'h00);
    end
    end_test("events");
    wr(UHIE_ADDR_IER, 8'h02);
    waitc(2);
    check({7'h00, chan_int}, 8'h01);
    // shifter plus sixteen slots take seventeen; the eighteenth is dropped
    for (int i = 0; i < 18; i++) begin
      v = 8'($urandom);
      if (i < 17) exp_q.push_back(v);
      wr(UHIE_ADDR_HOLDING, v);
    end
    waitc(2);
    check({7'h00, tx_space}, 8'h00);
    check({7'h00, chan_int}, 8'h00);
    for (int k = 0; k < 20000 && line.got_q.size() < 17; k++) waitc(1);
    waitc(200);
    check(8'(line.got_q.size()), 8'h11);
    foreach (exp_q[i]) check(line.got_q[i], exp_q[i]);
    rd(UHIE_ADDR_LSR, v);
    check(v, 8'h60);
    check({7'h00, chan_int}, 8'h01);
    end_test("transmit");
    // without fifos the holding stage keeps one byte; a third write is dropped
    ctl.fifo_en = 1'b0;
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      if (i < 2) exp_q.push_back(v);
      wr(UHIE_ADDR_HOLDING, v);
    end
    rd(UHIE_ADDR_LSR, v);
    check({7'h00, v[5]}, 8'h00);
    for (int k = 0; k < 3000 && line.got_q.size() < 19; k++) waitc(1);
    waitc(200);
    check(8'(line.got_q.size()), 8'h13);
    check(line.got_q[17], exp_q[17]);
    check(line.got_q[18], exp_q[18]);
    end_test("holding");
    final_report();
  end
endmodule
